/* src/seecp_params.svh */
// seecp_params.svh: constants of the serial eeprom command port
// assumes nothing; included by the package user files by bare name
`ifndef SEECP_PARAMS_SVH
`define SEECP_PARAMS_SVH

// reference clock
`define SEECP_CLK_PERIOD_NS 20
// least chip-select low time before status is shown, and its cycle count
`define SEECP_TCSL_NS 250
`define SEECP_TCSL_CYC ((`SEECP_TCSL_NS + `SEECP_CLK_PERIOD_NS - 1) / `SEECP_CLK_PERIOD_NS)
// self-timed programming time, plain default, and its cycle count
`define SEECP_PROG_TIME_NS 5000000
`define SEECP_PROG_CYC (`SEECP_PROG_TIME_NS / `SEECP_CLK_PERIOD_NS)
// address bits in 8-bit organisation; 16-bit uses one fewer
`define SEECP_ADDR8_W 11
// word widths
`define SEECP_WIDE_BITS 16
`define SEECP_NARROW_BITS 8
// opcodes following the start bit
`define SEECP_OP_EXT 2'h0
`define SEECP_OP_WRITE 2'h1
`define SEECP_OP_READ 2'h2
`define SEECP_OP_ERASE 2'h3
// top two address bits under the extended opcode
`define SEECP_EXT_LOCK 2'h0
`define SEECP_EXT_WRALL 2'h1
`define SEECP_EXT_ERALL 2'h2
`define SEECP_EXT_UNLOCK 2'h3

`endif

/* src/seecp_pkg.sv */
// seecp_pkg: types of the serial eeprom command port
// assumes seecp_params.svh holds all numeric constants
package seecp_pkg;
  // frame decoder states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OPC   = 3'h1,
    ST_ADDR  = 3'h2,
    ST_DATA  = 3'h3,
    ST_READ  = 3'h4,
    ST_ARMED = 3'h5,
    ST_SKIP  = 3'h6
  } seecp_state_t;
  // kind of self-timed programming cycle
  typedef enum logic [1:0] {
    PK_ERASE = 2'h0,
    PK_WRITE = 2'h1,
    PK_ERALL = 2'h2,
    PK_WRALL = 2'h3
  } seecp_pkind_t;
endpackage

/* src/seecp_prog_if.sv */
// seecp_prog_if: link between the frame decoder and the programming timer
// assumes both ends run on the same reference clock
`timescale 1ns/100ps
interface seecp_prog_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport eng (input start, output busy, output done);
endinterface

/* src/seecp_prog_timer.sv */
// seecp_prog_timer: self-timed programming cycle of the eeprom
// assumes a synchronous start pulse on the reference clock
`timescale 1ns/100ps
`include "seecp_params.svh"
module seecp_prog_timer #(
  parameter int unsigned PROG_CYC = `SEECP_PROG_CYC
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // decoder side
  seecp_prog_if.eng bus
);
  import seecp_pkg::*;

  localparam int unsigned CW = $clog2(PROG_CYC + 1);

  // refuse a cycle count the counter cannot serve
  generate
    if (PROG_CYC < 1) begin : g_bad
      $error("seecp_prog_timer: PROG_CYC must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_r;

  // once started, runs to the end whatever the select pin does
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.busy <= 1'b0;
      bus.done <= 1'b0;
      cnt_r <= '0;
    end else if (i_clk_en) begin
      bus.done <= 1'b0;
      if (!bus.busy && bus.start) begin
        bus.busy <= 1'b1;
        cnt_r <= CW'(PROG_CYC - 1);
      end else if (bus.busy) begin
        if (cnt_r == '0) begin
          bus.busy <= 1'b0;
          bus.done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule

/* src/seecp_top.sv */
// seecp_top: command front end of a three-wire serial eeprom
// assumes select, serial clock, data-in and the width and permit straps arrive asynchronously, i_fixed_supply static
// and that the word array answers i_mem_rdata one clock after o_mem_addr
//
// Overview of operation
// - word width is 16 bits with organisation pin high, 8 bits when low.
// - instruction, address and write data are sampled on serial clock rise.
// - data-out floats except for read data and ready/busy reporting.
// - status drives data-out low while programming, high when ready.
// - data-out floats on every falling edge of chip select.
// - start bit is first clock rise with select and data-in both high.
// - nothing is read, written, erased or unlocked before a start bit.
// - raising chip select leaves the standby state.
// - an instruction runs only once all its bits have been clocked in.
// - read drives one zero bit right after the last address bit.
// - after power-up erase and write are locked until unlocked.
// - a low program-permit pin blocks every array change.
// - single-word erase sets every bit of the word to one.
// - low-voltage parts start at select fall, fixed-supply at last clock.
// - after at least 250 ns select low, status shows during programming.
// - start bit then select low clears status after the cycle ends.
// - whole-array erase sets all bits to one in the same timed cycle.
// - whole-array erase completes with no further serial clocks.
// - opcodes 10 read, 01 write, 11 erase, 00 extended by top address bits.
// - unlock holds until a lock instruction or power removal.
// - reads run whether locked or unlocked.
// - select low resets decoding, a running program cycle completes.
// - with select held high a read continues at following addresses.
`timescale 1ns/100ps
`include "seecp_params.svh"
module seecp_top #(
  parameter int unsigned ADDR_W = `SEECP_ADDR8_W,
  parameter int unsigned PROG_CYC = `SEECP_PROG_CYC
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // serial pins from the host
  input wire logic i_cs,
  input wire logic i_sclk,
  input wire logic i_di,
  // serial data out, enable low while driving
  output logic o_do,
  output logic o_do_oe_n,
  // straps and variant selection
  input wire logic i_word_width_select,
  input wire logic i_program_permit_pin,
  input wire logic i_fixed_supply,
  // word array port
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [15:0] i_mem_rdata,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_wr,
  output logic o_mem_all,
  // status
  output logic o_busy,
  output logic o_unlocked,
  output logic o_standby
);
  import seecp_pkg::*;

  localparam int unsigned TCSL_CYC = `SEECP_TCSL_CYC;

  // refuse address widths the bit counter cannot serve
  generate
    if (ADDR_W < 4 || ADDR_W > 16) begin : g_bad
      $error("seecp_top: ADDR_W must lie between 4 and 16");
    end
  endgenerate

  // address bits minus one for the organisation
  function automatic logic [4:0] addr_last(input logic wide);
    return wide ? 5'(ADDR_W - 2) : 5'(ADDR_W - 1);
  endfunction

  // data bits minus one for the organisation
  function automatic logic [4:0] data_last(input logic wide);
    return wide ? 5'(`SEECP_WIDE_BITS - 1) : 5'(`SEECP_NARROW_BITS - 1);
  endfunction

  seecp_prog_if pif ();

  logic [1:0] rst_s_r;
  logic rst_n;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic ck_d_r;
  logic cs_d_r;
  logic cs;
  logic ck;
  logic di;
  logic wide;
  logic permit_pin;
  logic ck_rise;
  logic cs_fall;
  logic cs_rise;
  seecp_state_t state_r;
  logic [4:0] cnt_r;
  logic [1:0] op_r;
  logic [ADDR_W-1:0] addr_sh_r;
  logic [15:0] dat_sh_r;
  logic start_seen_r;
  seecp_pkind_t kind_r;
  logic unlocked_r;
  logic [15:0] rd_sh_r;
  logic rd_load_r;
  logic rd_cap_r;
  logic [3:0] csl_cnt_r;
  logic stat_pend_r;
  logic stat_on_r;
  logic last_bit;
  logic [ADDR_W-1:0] a_next;
  logic [15:0] d_next;
  logic [1:0] ext;
  logic ev_unlock;
  logic ev_lock;
  logic ev_read;
  logic ev_data;
  logic ev_prog;
  logic permit;
  seecp_pkind_t prog_kind;

  // reset release through two flip-flops
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s_r <= 2'h0;
    end else if (i_clk_en) begin
      rst_s_r <= {rst_s_r[0], 1'b1};
    end
  end
  assign rst_n = rst_s_r[1];

  // two-stage synchronisers for every pin but i_fixed_supply, then edge history
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      ck_d_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else if (i_clk_en) begin
      sync1_r <= {i_cs, i_sclk, i_di, i_word_width_select, i_program_permit_pin};
      sync2_r <= sync1_r;
      ck_d_r <= sync2_r[3];
      cs_d_r <= sync2_r[4];
    end
  end

  // synchronised pin levels and edges
  assign cs = sync2_r[4];
  assign ck = sync2_r[3];
  assign di = sync2_r[2];
  assign wide = sync2_r[1];
  assign permit_pin = sync2_r[0];
  assign ck_rise = ck & ~ck_d_r & cs;
  assign cs_fall = ~cs & cs_d_r;
  assign cs_rise = cs & ~cs_d_r;

  // instruction decode at the final bit of the address and data fields
  always_comb begin
    last_bit = ck_rise && (cnt_r == 5'h00);
    a_next = {addr_sh_r[ADDR_W-2:0], di};
    d_next = {dat_sh_r[14:0], di};
    ext = wide ? a_next[ADDR_W-2 -: 2] : a_next[ADDR_W-1 -: 2];
    ev_unlock = 1'b0;
    ev_lock = 1'b0;
    ev_read = 1'b0;
    ev_data = 1'b0;
    ev_prog = 1'b0;
    prog_kind = kind_r;
    if (last_bit && state_r == ST_ADDR) begin
      unique case (op_r)
        `SEECP_OP_READ: ev_read = 1'b1;
        `SEECP_OP_WRITE: ev_data = 1'b1;
        `SEECP_OP_ERASE: begin
          ev_prog = 1'b1;
          prog_kind = PK_ERASE;
        end
        `SEECP_OP_EXT: begin
          unique case (ext)
            `SEECP_EXT_UNLOCK: ev_unlock = 1'b1;
            `SEECP_EXT_LOCK: ev_lock = 1'b1;
            `SEECP_EXT_WRALL: ev_data = 1'b1;
            `SEECP_EXT_ERALL: begin
              ev_prog = 1'b1;
              prog_kind = PK_ERALL;
            end
          endcase
        end
      endcase
    end else if (last_bit && state_r == ST_DATA) begin
      ev_prog = 1'b1;
    end
  end

  // programming needs the unlock, the permit pin and an idle timer
  assign permit = unlocked_r & permit_pin & ~pif.busy;

  // frame decoder; select low clears it at once
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      op_r <= 2'h0;
      addr_sh_r <= '0;
      dat_sh_r <= 16'h0000;
      start_seen_r <= 1'b0;
      kind_r <= PK_ERASE;
    end else if (i_clk_en) begin
      if (!cs) begin
        state_r <= ST_IDLE;
        start_seen_r <= 1'b0;
      end else if (ck_rise) begin
        unique case (state_r)
          ST_IDLE: begin
            if (di) begin
              state_r <= ST_OPC;
              cnt_r <= 5'h01;
              start_seen_r <= 1'b1;
              addr_sh_r <= '0;
            end
          end
          ST_OPC: begin
            op_r <= {op_r[0], di};
            if (cnt_r == 5'h00) begin
              state_r <= ST_ADDR;
              cnt_r <= addr_last(wide);
            end else begin
              cnt_r <= cnt_r - 5'h01;
            end
          end
          ST_ADDR: begin
            addr_sh_r <= a_next;
            if (ev_read) begin
              state_r <= ST_READ;
              cnt_r <= data_last(wide);
            end else if (ev_data) begin
              state_r <= ST_DATA;
              cnt_r <= data_last(wide);
              kind_r <= (op_r == `SEECP_OP_WRITE) ? PK_WRITE : PK_WRALL;
            end else if (ev_prog) begin
              kind_r <= prog_kind;
              state_r <= (permit && !i_fixed_supply) ? ST_ARMED : ST_SKIP;
            end else if (last_bit) begin
              state_r <= ST_SKIP;
            end else begin
              cnt_r <= cnt_r - 5'h01;
            end
          end
          ST_DATA: begin
            dat_sh_r <= d_next;
            if (ev_prog) begin
              state_r <= (permit && !i_fixed_supply) ? ST_ARMED : ST_SKIP;
            end else begin
              cnt_r <= cnt_r - 5'h01;
            end
          end
          ST_READ: begin
            cnt_r <= (cnt_r == 5'h00) ? data_last(wide) : cnt_r - 5'h01;
          end
          ST_ARMED, ST_SKIP: begin
            state_r <= state_r; // clocks are ignored until select falls
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // erase/write lock, locked from reset
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_r <= 1'b0;
    end else if (i_clk_en) begin
      if (ev_unlock) begin
        unlocked_r <= 1'b1;
      end else if (ev_lock) begin
        unlocked_r <= 1'b0;
      end
    end
  end

  // launch of the self-timed cycle
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pif.start <= 1'b0;
    end else if (i_clk_en) begin
      pif.start <= (ev_prog && permit && i_fixed_supply)
        || (state_r == ST_ARMED && cs_fall && !pif.busy);
    end
  end

  // array address, write data and the strobe at the end of the cycle
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mem_addr <= '0;
      o_mem_wdata <= 16'h0000;
      o_mem_wr <= 1'b0;
      o_mem_all <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_wr <= pif.done;
      if (ev_read || (ev_data && !pif.busy)) begin
        o_mem_addr <= a_next;
      end else if (ev_prog && permit && state_r == ST_ADDR) begin
        o_mem_addr <= a_next;
      end else if (state_r == ST_READ && last_bit) begin
        o_mem_addr <= o_mem_addr + 1'b1;
      end
      if (ev_prog && permit) begin
        o_mem_all <= (prog_kind == PK_ERALL) || (prog_kind == PK_WRALL);
        if (prog_kind == PK_ERASE || prog_kind == PK_ERALL) begin
          o_mem_wdata <= wide ? 16'hFFFF : 16'h00FF;
        end else begin
          o_mem_wdata <= wide ? d_next : {8'h00, d_next[7:0]};
        end
      end
    end
  end

  // read word fetch, two cycles after the address moves
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_load_r <= 1'b0;
      rd_cap_r <= 1'b0;
      rd_sh_r <= 16'h0000;
    end else if (i_clk_en) begin
      rd_load_r <= ev_read || (state_r == ST_READ && last_bit && cs);
      rd_cap_r <= rd_load_r;
      if (rd_cap_r) begin
        rd_sh_r <= wide ? i_mem_rdata : {i_mem_rdata[7:0], 8'h00};
      end else if (state_r == ST_READ && ck_rise) begin
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
      end
    end
  end

  // ready/busy status: armed by a launch, shown after a long enough low
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csl_cnt_r <= 4'h0;
      stat_pend_r <= 1'b0;
      stat_on_r <= 1'b0;
    end else if (i_clk_en) begin
      if (cs) begin
        csl_cnt_r <= 4'h0;
      end else if (csl_cnt_r != 4'hF) begin
        csl_cnt_r <= csl_cnt_r + 4'h1;
      end
      if (pif.start) begin
        stat_pend_r <= 1'b1; // set wins over the clear
      end else if (cs_fall && start_seen_r && !pif.busy) begin
        stat_pend_r <= 1'b0;
      end
      if (!cs) begin
        stat_on_r <= 1'b0;
      end else if (cs_rise) begin
        stat_on_r <= stat_pend_r && (32'(csl_cnt_r) >= TCSL_CYC);
      end
    end
  end

  // data-out driver
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_do <= 1'b1;
      o_do_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (!cs) begin
        o_do_oe_n <= 1'b1;
      end else if (ev_read) begin
        o_do <= 1'b0;
        o_do_oe_n <= 1'b0;
      end else if (state_r == ST_READ) begin
        if (ck_rise) begin
          o_do <= rd_sh_r[15];
        end
      end else if (stat_on_r) begin
        o_do <= ~pif.busy;
        o_do_oe_n <= 1'b0;
      end else begin
        o_do_oe_n <= 1'b1;
      end
    end
  end

  // status copies
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_busy <= 1'b0;
      o_unlocked <= 1'b0;
      o_standby <= 1'b1;
    end else if (i_clk_en) begin
      o_busy <= pif.busy;
      o_unlocked <= unlocked_r;
      o_standby <= ~cs & ~pif.busy;
    end
  end

  seecp_prog_timer #(
    .PROG_CYC(PROG_CYC)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .bus(pif.eng)
  );
endmodule

/* sim/seecp_checker.sv */
// seecp_checker: pin timing properties of the serial eeprom command port
// assumes binding into seecp_top; watches its ports only
`timescale 1ns/100ps
module seecp_checker #(
  parameter int unsigned PROG_CYC = 50
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // pins and straps
  input wire logic i_cs,
  input wire logic i_program_permit_pin,
  input wire logic o_do,
  input wire logic o_do_oe_n,
  // array and status
  input wire logic o_mem_wr,
  input wire logic o_busy,
  input wire logic o_unlocked,
  input wire logic o_standby
);
  // window of the self-timed cycle, slack for sync stages
  localparam int PLO = PROG_CYC - 4;
  localparam int PHI = PROG_CYC + 4;
  default clocking cb @(posedge i_ref_clk); endclocking
  // a frozen clock enable stretches every timing, so attempts then are dropped
  default disable iff (!i_reset_n || !i_clk_en);
  // data-out pin, status levels, protection, cycle timing, standby
  chk_do_release: assert property (!i_cs [*6] |-> o_do_oe_n)
    else $error("data-out driven with select low");
  chk_status_busy: assert property ($rose(i_cs) ##1 o_busy [*6] |-> (o_do_oe_n || !o_do))
    else $error("status high while busy");
  chk_status_ready: assert property ($rose(i_cs) ##1 !o_busy [*6] |-> (o_do_oe_n || o_do))
    else $error("status low while ready");
  chk_lock_guard: assert property ($rose(o_busy) |-> $past(o_unlocked, 3))
    else $error("program cycle while locked");
  chk_permit_guard: assert property ($rose(o_busy) |-> $past(i_program_permit_pin, 8))
    else $error("program cycle with permit low");
  chk_prog_length: assert property ($rose(o_busy) |-> ##[PLO:PHI] o_mem_wr)
    else $error("program cycle did not end in time");
  chk_wr_pulse: assert property (o_mem_wr |-> $past(o_busy) ##1 !o_mem_wr)
    else $error("array write outside a program cycle");
  chk_standby_exit: assert property (i_cs [*5] |-> !o_standby)
    else $error("standby with select high");
  chk_standby_back: assert property ((!i_cs && !o_busy) [*5] |-> o_standby)
    else $error("no standby when idle");
  chk_unlock_hold: assert property ($changed(o_unlocked) |-> $past(i_cs))
    else $error("lock state changed outside a frame");
endmodule
bind seecp_top seecp_checker #(.PROG_CYC(PROG_CYC)) u_chk (
  .i_ref_clk, .i_reset_n, .i_clk_en, .i_cs, .i_program_permit_pin, .o_do, .o_do_oe_n,
  .o_mem_wr, .o_busy, .o_unlocked, .o_standby
);

/* sim/seecp_host_model.sv */
// seecp_host_model: behavioural host driving select, serial clock and data-in
// assumes the bench reference clock; pins change on its falling edge
`timescale 1ns/100ps
module seecp_host_model (
  // reference clock
  input wire logic i_ref_clk,
  // serial pins
  output logic o_cs,
  output logic o_sclk,
  output logic o_di,
  input wire logic i_do,
  input wire logic i_do_oe_n
);
  logic last_r = 1'b1;
  logic line;
  logic [31:0] rx_bits = '0;
  // released pin has no pull: show inverse of last driven level
  assign line = i_do_oe_n ? ~last_r : i_do;
  always @(posedge i_ref_clk) begin
    if (!i_do_oe_n) begin
      last_r <= i_do;
    end
  end
  initial begin
    o_cs = 1'b0;
    o_sclk = 1'b0;
    o_di = 1'b0;
  end
  // wait reference cycles
  task automatic gap(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // raise select with clock low, no false start
  task automatic select();
    gap(1);
    o_sclk = 1'b0;
    o_cs = 1'b1;
  endtask
  // n bits msb first at 160 ns; data-out sampled before each rise and once after
  task automatic send(input logic [31:0] b, input int n);
    if (!o_cs) select();
    for (int i = n - 1; i >= 0; i--) begin
      o_di = b[i];
      gap(4);
      rx_bits = {rx_bits[30:0], line};
      o_sclk = 1'b1;
      gap(4);
      o_sclk = 1'b0;
    end
    gap(4);
    rx_bits = {rx_bits[30:0], line};
  endtask
  // drop select, clock stays still, long enough for status
  task automatic deselect();
    o_cs = 1'b0;
    o_di = 1'b0;
    gap(15);
  endtask
endmodule

/* sim/seecp_top_tb.sv */
// seecp_top_tb: self-checking bench of the serial eeprom command port
// assumes seecp_top, the host model and the bound checker are compiled
`timescale 1ns/100ps
`include "seecp_params.svh"
module seecp_top_tb;
  logic clk = 1'b0;
  logic rst_n, wws, permit, fixed, clk_en;
  logic cs, sclk, di, do_pin, do_oe_n, mem_wr, mem_all, busy, unlocked, standby;
  logic [10:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] rdata;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // array contents as a function of the address
  function automatic logic [15:0] word(input logic [10:0] a);
    return {~a[7:0], a[7:0] ^ 8'h3C};
  endfunction
  assign rdata = word(mem_addr);
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end
  seecp_host_model host (.i_ref_clk(clk), .o_cs(cs), .o_sclk(sclk), .o_di(di),
    .i_do(do_pin), .i_do_oe_n(do_oe_n));
  seecp_top #(.ADDR_W(11), .PROG_CYC(50)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(clk_en), .i_cs(cs), .i_sclk(sclk), .i_di(di), .o_do(do_pin),
    .o_do_oe_n(do_oe_n), .i_word_width_select(wws), .i_program_permit_pin(permit),
    .i_fixed_supply(fixed), .o_mem_addr(mem_addr), .i_mem_rdata(rdata),
    .o_mem_wdata(mem_wdata), .o_mem_wr(mem_wr), .o_mem_all(mem_all), .o_busy(busy),
    .o_unlocked(unlocked), .o_standby(standby));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // wait for the array write and judge it
  task automatic wait_prog(input logic [10:0] a, input logic [15:0] wd, input logic all);
    int k;
    k = 0;
    while (mem_wr !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    check("prog", 32'({mem_wr, mem_all, all ? 11'h0 : mem_addr, mem_wdata}),
      32'({1'b1, all, all ? 11'h0 : a, wd}));
  endtask
  // frame, deselect, then whether a cycle started
  task automatic prog(input logic [31:0] b, input int n, input logic exp);
    int k;
    host.send(b, n);
    host.deselect();
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check("busy", 32'(busy), 32'(exp));
  endtask
  task automatic s_reset();
    check("reset", 32'({do_oe_n, unlocked, busy, standby}), 32'h9);
  endtask
  task automatic s_read();
    logic [15:0] w0, w1;
    w0 = word(11'h7FF);
    w1 = word(11'h000);
    host.send(32'({1'b1, `SEECP_OP_READ, 11'h7FF, 16'h0}), 30);
    host.deselect();
    check("read8", 32'(host.rx_bits[16:0]), 32'({1'b0, w0[7:0], w1[7:0]}));
    wws = 1'b1;
    host.gap(4);
    host.send(32'({1'b1, `SEECP_OP_READ, 10'h000, 16'h0}), 29);
    host.deselect();
    check("read16", 32'(host.rx_bits[16:0]), 32'({1'b0, w1}));
    wws = 1'b0;
  endtask
  task automatic s_erase();
    host.send(32'({6'h0, 1'b1, `SEECP_OP_EXT, `SEECP_EXT_UNLOCK, 9'h0}), 20);
    host.deselect();
    check("unlock", 32'(unlocked), 32'h1);
    prog(32'({1'b1, `SEECP_OP_ERASE, 11'h155}), 14, 1'b1);
    host.select();
    host.gap(8);
    check("busy flag", 32'({do_oe_n, do_pin}), 32'h0);
    wait_prog(11'h155, 16'h00FF, 1'b0);
    host.gap(4);
    check("ready flag", 32'({do_oe_n, do_pin}), 32'h1);
    host.send(32'h1, 1);
    host.deselect();
    host.select();
    host.gap(8);
    check("flag clear", 32'(do_oe_n), 32'h1);
    host.deselect();
  endtask
  task automatic s_write();
    fixed = 1'b1;
    host.send(32'({1'b1, `SEECP_OP_WRITE, 11'h2A3, 8'hC5}), 22);
    host.gap(6);
    check("fixed start", 32'(busy), 32'h1);
    host.deselect();
    wait_prog(11'h2A3, 16'h00C5, 1'b0);
    fixed = 1'b0;
  endtask
  task automatic s_all();
    prog(32'({1'b1, `SEECP_OP_EXT, `SEECP_EXT_ERALL, 9'h0}), 14, 1'b1);
    wait_prog(11'h0, 16'h00FF, 1'b1);
    prog(32'({1'b1, `SEECP_OP_EXT, `SEECP_EXT_WRALL, 9'h0, 8'h96}), 22, 1'b1);
    // enable low must hold the running cycle past its normal length
    clk_en = 1'b0;
    host.gap(60);
    check("freeze", 32'({busy, mem_wr}), 32'h2);
    clk_en = 1'b1;
    wait_prog(11'h0, 16'h0096, 1'b1);
  endtask
  task automatic s_protect();
    permit = 1'b0;
    prog(32'({1'b1, `SEECP_OP_ERASE, 11'h010}), 14, 1'b0);
    permit = 1'b1;
    prog(32'hE0, 8, 1'b0);
    host.send(32'({1'b1, `SEECP_OP_EXT, `SEECP_EXT_LOCK, 9'h0}), 14);
    host.deselect();
    check("lock", 32'(unlocked), 32'h0);
    prog(32'({1'b1, `SEECP_OP_ERASE, 11'h010}), 14, 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    wws = 1'b0;
    permit = 1'b1;
    fixed = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    s_reset();
    s_read();
    s_erase();
    s_write();
    s_all();
    s_protect();
    final_report();
  end
endmodule
